// ---- hdl/flag_fifo.sv ----
// Flop-based FIFO with a per-entry flag summary.
// Assumes the owner never pushes while full; limit_one shrinks it to one stage.
`timescale 1ns/10ps
`default_nettype none
module flag_fifo import status_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic             i_clk,       // clock
  input  wire logic             i_rst_n,     // async reset
  input  wire logic             i_limit_one, // single holding stage
  input  wire logic             i_flush,     // drop contents
  input  wire logic             i_push,      // write entry
  input  wire logic [W-1:0]     i_data,      // entry in
  input  wire logic             i_pop,       // drop head
  output logic      [W-1:0]     o_head,      // head entry
  output logic      [CNT_W-1:0] o_count,     // entries held
  output logic                  o_full,      // no room
  output logic                  o_empty,     // nothing held
  output logic                  o_any_flag   // flagged entry held
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PTR_W-1:0]        rd;
    logic [PTR_W-1:0]        wr;
    logic [CNT_W-1:0]        cnt;
  } fst_t;
  fst_t s_r, s_nxt;
  logic [DEPTH-1:0] flag_v;
  logic             do_push, do_pop;

  assign o_count = s_r.cnt;
  assign o_empty = (s_r.cnt == '0);
  assign o_full  = i_limit_one ? !o_empty : (s_r.cnt == CNT_W'(DEPTH));
  assign o_head  = s_r.mem[s_r.rd];
  assign do_push = i_push && !o_full;
  assign do_pop  = i_pop && !o_empty;

  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_flag
    logic [PTR_W-1:0] rel;
    assign rel       = PTR_W'(g) - s_r.rd;
    assign flag_v[g] = ({1'b0, rel} < s_r.cnt) && (|s_r.mem[g][W-1:W-NFLAG]);
  end
  assign o_any_flag = |flag_v;

  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wr] = i_data;
      s_nxt.wr          = s_r.wr + PTR_W'(1);
    end
    if (do_pop) s_nxt.rd = s_r.rd + PTR_W'(1);
    s_nxt.cnt = s_r.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
    if (i_flush) begin
      s_nxt.rd  = '0;
      s_nxt.wr  = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) s_r <= '0;
    else          s_r <= s_nxt;
  end
endmodule
`default_nettype wire

// ---- hdl/irq_sticky.sv ----
// Sticky interrupt status with write-one-to-clear and enable register.
// Assumes event strobes last one cycle; an event in a clear cycle stays set.
`timescale 1ns/10ps
`default_nettype none
module irq_sticky import status_pkg::*; (
  input  wire logic            i_clk,    // clock
  input  wire logic            i_rst_n,  // async reset
  input  wire logic [NEVT-1:0] i_evt,    // event strobes
  input  wire logic [NEVT-1:0] i_clr,    // clear strobes
  input  wire logic            i_en_we,  // enable write
  input  wire logic [NEVT-1:0] i_en_d,   // enable value
  output logic      [NEVT-1:0] o_status, // sticky bits
  output logic      [NEVT-1:0] o_enable, // enable bits
  output logic                 o_irq     // any enabled bit
);
  typedef struct packed {
    logic [NEVT-1:0] stat;
    logic [NEVT-1:0] en;
  } ist_t;
  ist_t s_r, s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.stat = (s_r.stat & ~i_clr) | i_evt;
    if (i_en_we) s_nxt.en = i_en_d;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) s_r <= '{stat: '0, en: IEN_RST};
    else          s_r <= s_nxt;
  end

  assign o_status = s_r.stat;
  assign o_enable = s_r.en;
  assign o_irq    = |(s_r.stat & s_r.en);
endmodule
`default_nettype wire

// ---- hdl/line_status.sv ----
// Line status block of one UART channel with its receive and transmit FIFOs.
// Assumes an APB master, a receiver that reports each frame with its error
// flags, and a transmitter that takes characters from the holding stage.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module line_status import status_pkg::*; (
  input  wire logic        i_clk,       // 20 MHz clock
  input  wire logic        i_rst_n,     // async reset, active low
  input  wire logic        i_psel,      // APB select
  input  wire logic        i_penable,   // APB enable
  input  wire logic        i_pwrite,    // APB direction
  input  wire logic [7:0]  i_paddr,     // APB byte address
  input  wire logic [31:0] i_pwdata,    // APB write data
  output logic      [31:0] o_prdata,    // APB read data
  output logic             o_pready,    // APB ready
  output logic             o_pslverr,   // APB error
  input  wire logic        i_rx_valid,  // frame complete strobe
  input  wire logic [7:0]  i_rx_data,   // received character
  input  wire logic        i_rx_perr,   // parity wrong
  input  wire logic        i_rx_ferr,   // stop bit missing
  input  wire logic        i_rx_brk,    // frame held low
  input  wire logic        i_rx_in,     // serial input level
  output logic             o_tx_valid,  // character available
  output logic      [7:0]  o_tx_data,   // character to send
  input  wire logic        i_tx_take,   // shift stage loads
  input  wire logic        i_shift_idle, // shift stage idle
  output logic             o_irq        // interrupt request
);
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        fifo_en;
    logic        hold_ie;
    logic        ovr;
    logic        hd_ack;
    logic        err7;
    logic        brk_hold;
  } st_t;
  st_t s_r, s_nxt;

  logic             acc, rd_acc, wr_acc;
  logic             hit_data, hit_stat, hit_ctrl;
  logic             hit_istat, hit_iclr, hit_ien, mapped;
  logic             stat_rd;
  logic             rx_take, rx_push, rx_pop, rx_full, rx_empty, rx_any;
  logic             rx_flagged, ovr_evt;
  logic [RX_W-1:0]  rx_entry, rx_head;
  logic [CNT_W-1:0] rx_count;
  logic             tx_push, tx_pop, tx_full, tx_empty;
  logic [TX_W-1:0]  tx_head;
  logic [CNT_W-1:0] tx_count;
  logic             flush;
  logic [7:0]       status;
  logic [NEVT-1:0]  evt, iclr, istat, ien;
  logic             ien_we, irq_sticky_out, thre_evt;

  // One wait state: effects and read data are taken at the first access
  // edge, so the value read is the value that the read side effects acted on.
  assign acc    = i_psel && i_penable && !s_r.pready;
  assign rd_acc = acc && !i_pwrite;
  assign wr_acc = acc && i_pwrite;

  always_comb begin
    hit_data  = 1'b0;
    hit_stat  = 1'b0;
    hit_ctrl  = 1'b0;
    hit_istat = 1'b0;
    hit_iclr  = 1'b0;
    hit_ien   = 1'b0;
    if (i_paddr == OFS_DATA) begin
      hit_data = 1'b1;
    end else if (i_paddr == OFS_STAT) begin
      hit_stat = 1'b1;
    end else if (i_paddr == OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (i_paddr == OFS_ISTAT) begin
      hit_istat = 1'b1;
    end else if (i_paddr == OFS_ICLR) begin
      hit_iclr = 1'b1;
    end else if (i_paddr == OFS_IEN) begin
      hit_ien = 1'b1;
    end
  end
  assign mapped  = hit_data | hit_stat | hit_ctrl | hit_istat | hit_iclr | hit_ien;
  assign stat_rd = rd_acc && hit_stat;

  // Changing the FIFO mode empties both FIFOs
  assign flush = wr_acc && hit_ctrl && (i_pwdata[CTRL_FIFO] != s_r.fifo_en);

  // Receive path
  // A long break repeats frames; only the first is stored until the line idles
  assign rx_take    = i_rx_valid && !(i_rx_brk && s_r.brk_hold);
  assign rx_push    = rx_take && !rx_full;
  assign ovr_evt    = rx_take && rx_full;
  assign rx_pop     = rd_acc && hit_data && !rx_empty;
  assign rx_entry   = {i_rx_brk, i_rx_ferr, i_rx_perr, i_rx_data};
  assign rx_flagged = i_rx_brk | i_rx_ferr | i_rx_perr;

  flag_fifo #(
    .W          (RX_W)
  ) u_rx_fifo (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_limit_one(!s_r.fifo_en),
    .i_flush    (flush),
    .i_push     (rx_push),
    .i_data     (rx_entry),
    .i_pop      (rx_pop),
    .o_head     (rx_head),
    .o_count    (rx_count),
    .o_full     (rx_full),
    .o_empty    (rx_empty),
    .o_any_flag (rx_any)
  );

  // Transmit path
  assign tx_push    = wr_acc && hit_data && !tx_full;
  assign tx_pop     = i_tx_take && !tx_empty;
  assign o_tx_valid = !tx_empty;
  assign o_tx_data  = tx_head;

  flag_fifo #(
    .W          (TX_W)
  ) u_tx_fifo (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_limit_one(!s_r.fifo_en),
    .i_flush    (flush),
    .i_push     (tx_push),
    .i_data     (i_pwdata[7:0]),
    .i_pop      (tx_pop),
    .o_head     (tx_head),
    .o_count    (tx_count),
    .o_full     (tx_full),
    .o_empty    (tx_empty),
    .o_any_flag ()
  );

  // Line status assembly
  always_comb begin
    status           = 8'h00;
    status[ST_DR]    = !rx_empty;
    status[ST_OE]    = s_r.ovr;
    // Head flags hide after a status read until the next head arrives
    status[ST_PE]    = !rx_empty && !s_r.hd_ack && rx_head[RX_PE];
    status[ST_FE]    = !rx_empty && !s_r.hd_ack && rx_head[RX_FE];
    status[ST_BI]    = !rx_empty && !s_r.hd_ack && rx_head[RX_BI];
    // Holding stage empties when the shift stage loads; a write refills it
    status[ST_THRE]  = tx_empty;
    status[ST_TEMT]  = tx_empty && i_shift_idle;
    status[ST_FERR]  = s_r.fifo_en && s_r.err7 && rx_any;
  end

  // Interrupt events
  assign thre_evt        = tx_pop && (tx_count == CNT_W'(1)) && !tx_push;
  assign evt[EV_RX]      = rx_push;
  assign evt[EV_LERR]    = ovr_evt || (rx_push && rx_flagged);
  assign evt[EV_THRE]    = thre_evt;
  assign iclr            = (wr_acc && hit_iclr) ? i_pwdata[NEVT-1:0] : '0;
  assign ien_we          = wr_acc && hit_ien;

  irq_sticky u_irq (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_evt   (evt),
    .i_clr   (iclr),
    .i_en_we (ien_we),
    .i_en_d  (i_pwdata[NEVT-1:0]),
    .o_status(istat),
    .o_enable(ien),
    .o_irq   (irq_sticky_out)
  );

  assign o_irq = irq_sticky_out || (status[ST_THRE] && s_r.hold_ie);

  // State update
  always_comb begin
    s_nxt         = s_r;
    s_nxt.pready  = acc;
    s_nxt.pslverr = acc && !mapped;
    if (rd_acc) begin
      s_nxt.prdata = 32'h0000_0000;
      if (hit_data) begin
        s_nxt.prdata[7:0] = rx_empty ? 8'h00 : rx_head[7:0];
      end else if (hit_stat) begin
        s_nxt.prdata[7:0] = status;
      end else if (hit_ctrl) begin
        s_nxt.prdata[CTRL_FIFO]  = s_r.fifo_en;
        s_nxt.prdata[CTRL_THRIE] = s_r.hold_ie;
      end else if (hit_istat) begin
        s_nxt.prdata[NEVT-1:0] = istat;
      end else if (hit_ien) begin
        s_nxt.prdata[NEVT-1:0] = ien;
      end
    end
    if (wr_acc && hit_ctrl) begin
      s_nxt.fifo_en = i_pwdata[CTRL_FIFO];
      s_nxt.hold_ie = i_pwdata[CTRL_THRIE];
    end
    // Status read clears; a new event in the same cycle wins
    s_nxt.ovr  = (stat_rd ? 1'b0 : s_r.ovr) | ovr_evt;
    s_nxt.err7 = (stat_rd ? 1'b0 : s_r.err7) | (rx_push && rx_flagged);
    if (rx_pop || rx_empty || flush) begin
      s_nxt.hd_ack = 1'b0;
    end else if (stat_rd) begin
      s_nxt.hd_ack = 1'b1;
    end
    if (rx_push && i_rx_brk) begin
      s_nxt.brk_hold = 1'b1;
    end else if (i_rx_in) begin
      s_nxt.brk_hold = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r         <= '0;
      s_r.fifo_en <= FIFO_RST;
      s_r.hold_ie <= THRIE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata  = s_r.prdata;
  assign o_pready  = s_r.pready;
  assign o_pslverr = s_r.pslverr;
endmodule
`default_nettype wire

// ---- hdl/lsr_pkg.sv ----
// Constants and register map for the line status block.
// Assumes one 20 MHz clock and an APB master at the register side.
// Overview of operation
// - Bit 7 flags any error held in FIFO; here only errors received since the last status read
// - Reading line status clears bit 7
// - Non-FIFO: bit 6 while holding and shift empty
// - FIFO mode: bit 6 when FIFO, shift empty
// - Non-FIFO: bit 5 sets when holding moves out
// - Non-FIFO: host write clears bit 5
// - Bit 5 with enable raises interrupt
// - FIFO mode: bit 5 follows transmit FIFO empty
// - Bit 4 reports a break frame
// - One break character per break condition
// - Bit 3 reports missing stop bit
// - Framing flag belongs to FIFO head
// - Bit 2 reports parity error of head
// - Bit 1 on overrun, FIFO kept intact
// - Bit 0 while received data waits
package status_pkg;
  localparam int          DEPTH      = 16;
  localparam int          PTR_W      = 4;
  localparam int          CNT_W      = 5;
  localparam int          RX_W       = 11;
  localparam int          TX_W       = 8;
  localparam int          NFLAG      = 3;
  localparam int          NEVT       = 3;
  // Register byte addresses
  localparam logic [7:0]  OFS_DATA   = 8'h00;
  localparam logic [7:0]  OFS_STAT   = 8'h04;
  localparam logic [7:0]  OFS_CTRL   = 8'h08;
  localparam logic [7:0]  OFS_ISTAT  = 8'h0c;
  localparam logic [7:0]  OFS_ICLR   = 8'h10;
  localparam logic [7:0]  OFS_IEN    = 8'h14;
  // Control register fields
  localparam int          CTRL_FIFO  = 0;
  localparam int          CTRL_THRIE = 1;
  localparam logic        FIFO_RST   = 1'b0;
  localparam logic        THRIE_RST  = 1'b0;
  // Receive entry layout: {break, framing, parity, data}
  localparam int          RX_PE      = 8;
  localparam int          RX_FE      = 9;
  localparam int          RX_BI      = 10;
  // Line status bit positions
  localparam int          ST_DR      = 0;
  localparam int          ST_OE      = 1;
  localparam int          ST_PE      = 2;
  localparam int          ST_FE      = 3;
  localparam int          ST_BI      = 4;
  localparam int          ST_THRE    = 5;
  localparam int          ST_TEMT    = 6;
  localparam int          ST_FERR    = 7;
  // Interrupt event positions
  localparam int          EV_RX      = 0;
  localparam int          EV_LERR    = 1;
  localparam int          EV_THRE    = 2;
  localparam logic [2:0]  IEN_RST    = 3'h0;
endpackage

// ---- test/line_status_props.sv ----
// Port-level assertions for the line status block.
// Assumes the APB master holds its request until pready.
`timescale 1ns/10ps
`default_nettype none
module line_status_props import status_pkg::*; (
  input wire logic        i_clk,       // clock
  input wire logic        i_rst_n,     // async reset
  input wire logic        i_psel,      // APB select
  input wire logic        i_penable,   // APB enable
  input wire logic        i_pwrite,    // APB direction
  input wire logic [7:0]  i_paddr,     // APB address
  input wire logic [31:0] i_pwdata,    // APB write data
  input wire logic [31:0] o_prdata,    // APB read data
  input wire logic        o_pready,    // APB ready
  input wire logic        o_pslverr,   // APB error
  input wire logic        i_rx_valid,  // frame strobe
  input wire logic [7:0]  i_rx_data,   // received character
  input wire logic        i_rx_perr,   // parity flag
  input wire logic        i_rx_ferr,   // framing flag
  input wire logic        i_rx_brk,    // break flag
  input wire logic        i_rx_in,     // serial level
  input wire logic        o_tx_valid,  // character available
  input wire logic [7:0]  o_tx_data,   // character out
  input wire logic        i_tx_take,   // shift stage loads
  input wire logic        i_shift_idle, // shift stage idle
  input wire logic        o_irq        // interrupt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire rd_stat = o_pready && !i_pwrite && i_paddr == OFS_STAT;
  sequence s_acc; i_psel && i_penable && !o_pready; endsequence
  sequence s_done; o_pready ##1 !o_pready; endsequence
  property p_ready_next; s_acc |=> s_done; endproperty
  property p_ready_cause; o_pready |-> $past(i_psel && i_penable && !o_pready); endproperty
  property p_setup_wait; i_psel && !i_penable |-> !o_pready; endproperty
  property p_slverr;
    o_pready |-> o_pslverr == (i_paddr > OFS_IEN || i_paddr[1:0] != 2'b00);
  endproperty
  property p_upper_zero; o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0; endproperty
  property p_temt; rd_stat && o_prdata[ST_TEMT] |-> o_prdata[ST_THRE]; endproperty
  property p_tx_load;
    s_acc and (i_pwrite && i_paddr == OFS_DATA && !o_tx_valid) |=> o_tx_valid;
  endproperty
  property p_tx_hold;
    o_tx_valid && !i_tx_take && !(i_psel && i_penable && !o_pready && i_pwrite)
      |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  a_ready_cause: assert property (p_ready_cause) else $error("pready uncaused");
  a_setup_wait: assert property (p_setup_wait) else $error("pready in setup");
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_temt: assert property (p_temt) else $error("bit 6 without bit 5");
  a_tx_load: assert property (p_tx_load) else $error("write not held");
  a_tx_hold: assert property (p_tx_hold) else $error("holding stage lost");
endmodule
bind line_status line_status_props u_props (.i_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_valid,
  .i_rx_data, .i_rx_perr, .i_rx_ferr, .i_rx_brk, .i_rx_in, .o_tx_valid, .o_tx_data,
  .i_tx_take, .i_shift_idle, .o_irq);
`default_nettype wire

// ---- test/test_line_status.sv ----
// Testbench for the line status block: APB tasks, receive frames, shift model.
// Assumes the 20 MHz clock; each APB access waits for pready however long.
`timescale 1ns/10ps
`default_nettype none
module test_line_status import status_pkg::*;;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_perr;
  logic i_rx_ferr, i_rx_brk, i_rx_in, i_tx_take, i_shift_idle;
  logic o_pready, o_pslverr, o_tx_valid, o_irq, perr;
  logic [7:0]  i_paddr, i_rx_data, o_tx_data, gap, last;
  logic [31:0] i_pwdata, o_prdata, rdat;
  int          n_fail, tests_run;
  line_status u_dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_valid, .i_rx_data, .i_rx_perr,
    .i_rx_ferr, .i_rx_brk, .i_rx_in, .o_tx_valid, .o_tx_data, .i_tx_take,
    .i_shift_idle, .o_irq);
  tx_shift_model u_tx (.i_clk, .i_rst_n, .i_valid(o_tx_valid), .i_data(o_tx_data),
    .i_gap(gap), .o_take(i_tx_take), .o_empty(i_shift_idle), .o_last(last));
  initial begin
    i_clk = 0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rdat = o_prdata;
    perr = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic stat(input logic [7:0] m, input logic [7:0] e);
    apb(0, OFS_STAT, 0);
    chk("line_status", {24'h0, e & m}, rdat & {24'h0, m});
  endtask
  task automatic rx(input logic [7:0] d, input logic [2:0] f);
    @(posedge i_clk);
    i_rx_valid <= 1;
    i_rx_data <= d;
    {i_rx_brk, i_rx_ferr, i_rx_perr} <= f;
    @(posedge i_clk);
    i_rx_valid <= 0;
    // Let the stored frame reach the registers before the caller looks
    @(posedge i_clk);
  endtask
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_clk);
    n_fail++;
    end_sim();
  end
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_perr, i_rx_ferr} = 0;
    {i_paddr, i_pwdata, i_rx_data, i_rx_brk, n_fail, tests_run} = 0;
    i_rx_in = 1;
    gap = 8'd30;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1;
    stat(8'h9f, 8'h00);
    apb(0, 8'h18, 0);
    chk("slverr", 1, perr);
    apb(1, OFS_DATA, 32'h5a);
    stat(8'h60, 8'h00);
    repeat (35) @(posedge i_clk);
    stat(8'h60, 8'h20);
    chk("taken", 32'h5a, last);
    repeat (25) @(posedge i_clk);
    stat(8'h60, 8'h60);
    apb(1, OFS_CTRL, 32'h2);
    chk("irq", 1, o_irq);
    apb(1, OFS_CTRL, 0);
    chk("irq", 0, o_irq);
    apb(1, OFS_IEN, 32'h1);
    rx(8'hc3, 3'b001);
    chk("irq", 1, o_irq);
    apb(0, OFS_ISTAT, 0);
    chk("istat", 1, rdat & 32'h1);
    apb(1, OFS_ICLR, 32'h7);
    chk("irq", 0, o_irq);
    stat(8'h0d, 8'h05);
    stat(8'h04, 8'h00);
    rx(8'h11, 3'b000);
    stat(8'h03, 8'h03);
    apb(0, OFS_DATA, 0);
    chk("rx_data", 32'hc3, rdat);
    stat(8'h03, 8'h00);
    apb(1, OFS_CTRL, 32'h1);
    rx(8'h21, 3'b000);
    rx(8'h22, 3'b010);
    stat(8'h89, 8'h81);
    stat(8'h80, 8'h00);
    apb(0, OFS_DATA, 0);
    chk("rx_data", 32'h21, rdat);
    stat(8'h08, 8'h08);
    apb(0, OFS_DATA, 0);
    i_rx_in <= 0;
    rx(8'h00, 3'b100);
    rx(8'h00, 3'b100);
    i_rx_in <= 1;
    stat(8'h11, 8'h11);
    apb(0, OFS_DATA, 0);
    stat(8'h01, 8'h00);
    gap <= 8'd2;
    for (int k = 1; k < 4; k++) apb(1, OFS_DATA, k);
    stat(8'h60, 8'h00);
    repeat (100) @(posedge i_clk);
    stat(8'h60, 8'h60);
    chk("taken", 32'h3, last);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- test/tx_shift_model.sv ----
// Transmit shift stage model: waits i_gap idle cycles, takes a character,
// then stays busy for SHIFT cycles. Assumes tx_valid is offered as a level.
`timescale 1ns/10ps
`default_nettype none
module tx_shift_model #(
  parameter int SHIFT = 20
) (
  input  wire logic       i_clk,   // clock
  input  wire logic       i_rst_n, // async reset
  input  wire logic       i_valid, // character offered
  input  wire logic [7:0] i_data,  // character
  input  wire logic [7:0] i_gap,   // idle cycles before a take
  output logic            o_take,  // load strobe
  output logic            o_empty, // shift stage idle
  output logic      [7:0] o_last   // last character taken
);
  int busy;
  int idle;
  assign o_empty = (busy == 0) && !o_take;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 0;
      idle <= 0;
      o_take <= 1'b0;
      o_last <= 8'h00;
    end else begin
      o_take <= 1'b0;
      if (o_take) begin
        o_last <= i_data;
        busy <= SHIFT;
        idle <= 0;
      end else if (busy > 0) begin
        busy <= busy - 1;
      end else if (i_valid && idle >= int'(i_gap)) begin
        o_take <= 1'b1;
      end else if (i_valid) begin
        idle <= idle + 1;
      end
    end
  end
endmodule
`default_nettype wire
